// File: hdl/strap_debug_pkg.sv
// constants for the reset strap capture and debug test-point port
package strap_debug_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int TP_W = 8;
  localparam int SEL_W = 3;
  localparam int CNT_W = 8;
  localparam int DIV_W = 3;

  // ----------------------------------------
  // capture timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAPTURE_DELAY_NS = 1500;
  // least time, so round up to whole cycles
  localparam int CAPTURE_CYCLES = (CAPTURE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] CAPTURE_LAST = CNT_W'(CAPTURE_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAPTURE_COUNT = CNT_W'(CAPTURE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  // ----------------------------------------
  // output selection codes
  // ----------------------------------------
  localparam logic [SEL_W-1:0] MODE_QUIET = 3'h7;
  localparam logic [SEL_W-1:0] MODE_CLOCK = 3'h2;

  // per-pin clock source in clock debug mode
  localparam logic [2:0] SRC_LOW = 3'h0;
  localparam logic [2:0] SRC_60M = 3'h1;
  localparam logic [2:0] SRC_30M = 3'h2;
  localparam logic [2:0] SRC_15M = 3'h3;
  localparam logic [2:0] SRC_7M5 = 3'h4;
  // three bits per pin, pin 0 lowest: 60,30,7.5,low,15,60,low,low
  localparam logic [3*TP_W-1:0] CLOCK_DEBUG_SRC = 24'h00B111;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [TP_W-1:0] TP_OE_N_RST = 8'hFF;
  localparam logic [SEL_W-1:0] SEL_OE_N_RST = 3'h7;
  localparam logic [TP_W-1:0] CFG_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } port_state_e;

endpackage : strap_debug_pkg

// File: hdl/reset_strap_debug_port.sv
// reset strap capture and debug test-point output port
// ----------------------------------------
// Summary of operation
// - test points stay high-impedance while system reset is asserted
// - test points sampled about 1.5 us after reset release, timed by counter
// - test-point drivers enabled only after the capture
// - captured test-point levels held as initial configuration for the chip
// - select straps captured at same instant, then switched to outputs
// - captured select code picks the test-point output behaviour
// - weak pull-ups give code x111: all test points high-impedance
// - code x010 drives 60,30,7.5,low,15,60,low,low on bits 0..7
// - software may overwrite the output selection any time after start-up
// ----------------------------------------
`timescale 1ns/10ps
module reset_strap_debug_port
  import strap_debug_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_REF_60M,
  input wire logic [TP_W-1:0] I_TP,
  output logic [TP_W-1:0] O_TP,
  output logic [TP_W-1:0] O_TP_OE_N,
  input wire logic [SEL_W-1:0] I_SEL,
  input wire logic [SEL_W-1:0] I_SEL_DATA,
  output logic [SEL_W-1:0] O_SEL,
  output logic [SEL_W-1:0] O_SEL_OE_N,
  input wire logic I_SW_SEL_WR,
  input wire logic [SEL_W-1:0] I_SW_SEL,
  output logic [TP_W-1:0] O_CFG,
  output logic O_CFG_VALID,
  output logic [SEL_W-1:0] O_MODE
);

  // ----------------------------------------
  // capture sequencer
  // ----------------------------------------
  port_state_e state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [TP_W-1:0] next_cfg;
  logic next_cfg_valid;
  logic [SEL_W-1:0] next_mode;
  logic [SEL_W-1:0] next_sel;
  logic [SEL_W-1:0] next_sel_oe_n;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cfg = O_CFG;
    next_cfg_valid = O_CFG_VALID;
    next_mode = O_MODE;
    next_sel = I_SEL_DATA;
    next_sel_oe_n = O_SEL_OE_N;
    unique case (state)
      ST_WAIT: begin
        next_cnt = cnt + 8'h01;
        if (cnt == CAPTURE_LAST) begin
          next_state = ST_RUN;
          next_cfg = I_TP;
          next_cfg_valid = 1'b1;
          next_mode = I_SEL;
          next_sel_oe_n = 3'h0;
        end
      end
      ST_RUN: begin
        if (I_SW_SEL_WR) begin
          next_mode = I_SW_SEL;
        end
      end
      default: begin
        next_state = ST_WAIT;
        next_cnt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      state <= ST_WAIT;
      cnt <= 8'h00;
      O_CFG <= CFG_RST;
      O_CFG_VALID <= 1'b0;
      O_MODE <= MODE_QUIET;
      O_SEL <= 3'h0;
      O_SEL_OE_N <= SEL_OE_N_RST;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      O_CFG <= next_cfg;
      O_CFG_VALID <= next_cfg_valid;
      O_MODE <= next_mode;
      O_SEL <= next_sel;
      O_SEL_OE_N <= next_sel_oe_n;
    end
  end

  // ----------------------------------------
  // debug clock divider
  // ----------------------------------------
  // reference is a pin level sampled at 100 MHz, so the divided clocks
  // carry sampling jitter; good enough for a debug probe, not for timing
  logic ref_q, next_ref_q;
  logic ref_prev, next_ref_prev;
  logic [DIV_W-1:0] div, next_div;

  always_comb begin
    next_ref_q = I_REF_60M;
    next_ref_prev = ref_q;
    next_div = div;
    if (ref_q && !ref_prev) begin
      next_div = div + 3'h1;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ref_q <= 1'b0;
      ref_prev <= 1'b0;
      div <= 3'h0;
    end else begin
      ref_q <= next_ref_q;
      ref_prev <= next_ref_prev;
      div <= next_div;
    end
  end

  // ----------------------------------------
  // test-point output pattern
  // ----------------------------------------
  // per-bit nets: each generate slice drives only its own bit
  wire logic [TP_W-1:0] next_tp;
  wire logic [TP_W-1:0] next_tp_oe_n;

  genvar gi;
  generate
    for (gi = 0; gi < TP_W; gi++) begin : g_tp
      logic [2:0] src;
      logic pin_val;
      logic pin_oe_n;
      always_comb begin
        src = CLOCK_DEBUG_SRC[3*gi +: 3];
        pin_val = 1'b0;
        pin_oe_n = 1'b1;
        if (O_CFG_VALID) begin
          // selection picks behaviour; other codes stay quiet
          if (O_MODE == MODE_CLOCK) begin
            pin_oe_n = 1'b0;
            unique case (src)
              SRC_60M: pin_val = ref_q;
              SRC_30M: pin_val = div[0];
              SRC_15M: pin_val = div[1];
              SRC_7M5: pin_val = div[2];
              default: pin_val = 1'b0;
            endcase
          end
        end
      end
      assign next_tp[gi] = pin_val;
      assign next_tp_oe_n[gi] = pin_oe_n;
    end
  endgenerate

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_TP <= 8'h00;
      O_TP_OE_N <= TP_OE_N_RST;
    end else begin
      O_TP <= next_tp;
      O_TP_OE_N <= next_tp_oe_n;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [CNT_W-1:0] since_rel;
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      since_rel <= 8'h00;
    end else if (since_rel != CNT_MAX) begin
      since_rel <= since_rel + 8'h01;
    end
  end

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  tp_reset_hiz_a: assert property (disable iff (1'b0) I_RST |=> &O_TP_OE_N)
    else $error("test points driven during reset");
  capture_time_a: assert property ($rose(O_CFG_VALID) |-> since_rel == CAPTURE_COUNT)
    else $error("capture not at the timed instant");
  drive_after_cap_a: assert property (!O_CFG_VALID |-> &O_TP_OE_N && &O_SEL_OE_N)
    else $error("driver enabled before capture");
  cfg_value_a: assert property ($rose(O_CFG_VALID) |-> O_CFG == $past(I_TP))
    else $error("configuration not the sampled level");
  cfg_hold_a: assert property (O_CFG_VALID && $past(O_CFG_VALID) |-> $stable(O_CFG))
    else $error("configuration changed after capture");
  sel_capture_a: assert property ($rose(O_CFG_VALID) |->
      O_MODE == $past(I_SEL) && O_SEL_OE_N == 3'h0)
    else $error("select straps not captured or not driven");
  quiet_mode_a: assert property ($past(O_CFG_VALID) && $past(O_MODE) == MODE_QUIET
      |-> &O_TP_OE_N)
    else $error("test point driven in quiet mode");
  clock_pattern_a: assert property ($past(O_CFG_VALID) && $past(O_MODE) == MODE_CLOCK
      |-> O_TP_OE_N == 8'h00 && !O_TP[3] && !O_TP[6] && !O_TP[7]
      && O_TP[0] == O_TP[5] && O_TP[0] == $past(ref_q))
    else $error("clock debug pattern wrong");
  sw_select_a: assert property (O_CFG_VALID && I_SW_SEL_WR
      |=> O_MODE == $past(I_SW_SEL))
    else $error("software selection not taken");
  reload_a: assert property (disable iff (1'b0) I_RST |=> O_MODE == MODE_QUIET
      && !O_CFG_VALID)
    else $error("selection not reloaded at reset");

  capture_c: cover property ($rose(O_CFG_VALID));
  clock_mode_c: cover property (O_CFG_VALID && O_MODE == MODE_CLOCK ##4 O_TP[1]);
  sw_write_c: cover property (O_CFG_VALID && I_SW_SEL_WR && I_SW_SEL != O_MODE);

endmodule : reset_strap_debug_port

// File: test/strap_board.sv
// board straps, select jumpers and probe side of the debug pins
`timescale 1ns/10ps
module strap_board
  import strap_debug_pkg::*;
(
  input wire logic [TP_W-1:0] i_strap,
  input wire logic [SEL_W-1:0] i_jumper,
  input wire logic [TP_W-1:0] i_tp,
  input wire logic [TP_W-1:0] i_tp_oe_n,
  input wire logic [SEL_W-1:0] i_sel,
  input wire logic [SEL_W-1:0] i_sel_oe_n,
  output logic [TP_W-1:0] o_tp_pin,
  output logic [SEL_W-1:0] o_sel_pin
);
  // fitted jumper pulls low, else weak pull-up
  assign o_sel_pin = (i_sel & ~i_sel_oe_n) | (~i_jumper & i_sel_oe_n);
  // resistor straps lose to any driver
  assign o_tp_pin = (i_tp & ~i_tp_oe_n) | (i_strap & i_tp_oe_n);
endmodule : strap_board

// File: test/reset_strap_debug_port_test.sv
// self-checking bench for the reset strap debug port
`timescale 1ns/10ps
module reset_strap_debug_port_test
  import strap_debug_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ref60 = 1'b0;
  logic wr = 1'b0;
  logic [SEL_W-1:0] sw = 3'h0, sdat = 3'h0, jmp = 3'h0, sd, c;
  logic [TP_W-1:0] strap = 8'h00, cap, prev;
  logic [TP_W-1:0] tp_pin, o_tp, tp_oe_n, cfg;
  logic [SEL_W-1:0] sel_pin, o_sel, sel_oe_n, mode;
  logic cfg_valid;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  int r[8];

  always #5 clk = ~clk;

  reset_strap_debug_port u_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_REF_60M(ref60),
    .I_TP(tp_pin), .O_TP(o_tp), .O_TP_OE_N(tp_oe_n), .I_SEL(sel_pin), .I_SEL_DATA(sdat),
    .O_SEL(o_sel), .O_SEL_OE_N(sel_oe_n), .I_SW_SEL_WR(wr), .I_SW_SEL(sw), .O_CFG(cfg),
    .O_CFG_VALID(cfg_valid), .O_MODE(mode));
  strap_board u_board (.i_strap(strap), .i_jumper(jmp), .i_tp(o_tp), .i_tp_oe_n(tp_oe_n),
    .i_sel(o_sel), .i_sel_oe_n(sel_oe_n), .o_tp_pin(tp_pin), .o_sel_pin(sel_pin));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // divided clocks drift by a phase, so allow a small slack
  function automatic logic [7:0] near(input int a, input int b, input int tol);
    return 8'((a - b <= tol) && (b - a <= tol));
  endfunction : near

  task automatic boot(input logic [SEL_W-1:0] code, input logic [TP_W-1:0] tps);
    @(posedge clk);
    wr <= 1'b0;
    rst <= 1'b1;
    jmp <= ~code;
    strap <= tps;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("oe_rst", 8'hFF, tp_oe_n);
    chk("sel_oe_rst", 8'h07, 8'(sel_oe_n));
    chk("mode_rst", 8'h07, 8'(mode));
    chk("valid_rst", 8'h00, 8'(cfg_valid));
    for (n = 1; n <= 200; n++) begin
      @(posedge clk);
      // early write must be ignored
      wr <= (n == 60);
      sw <= 3'h2;
      #1;
      chk("oe_wait", 8'hFF, tp_oe_n);
      if (cfg_valid === 1'b1) break;
      chk("mode_wait", 8'h07, 8'(mode));
    end
    // capture never came: count it and stop
    if (n > 200) begin
      fail_count++;
      conclude();
    end else begin
      chk("cap_time", CAPTURE_COUNT, 8'(n));
      cap = tps;
      chk("cfg", tps, cfg);
      chk("mode_cap", 8'(code), 8'(mode));
      chk("sel_oe_cap", 8'h00, 8'(sel_oe_n));
    end
  endtask : boot

  task automatic sw_write(input logic [SEL_W-1:0] code);
    @(posedge clk);
    wr <= 1'b1;
    sw <= code;
    @(posedge clk);
    // strobe is a single-cycle pulse
    wr <= 1'b0;
    #1;
    chk("sw_mode", 8'(code), 8'(mode));
  endtask : sw_write

  task automatic watch(input logic [SEL_W-1:0] code);
    r = '{default: 0};
    prev = o_tp;
    for (n = 0; n < ((code == MODE_CLOCK) ? 400 : 30); n++) begin
      @(posedge clk);
      sd = sdat;
      ref60 <= 1'($urandom);
      sdat <= 3'($urandom);
      strap <= 8'($urandom);
      jmp <= 3'($urandom);
      #1;
      chk("sel_out", 8'(sd), 8'(o_sel));
      chk("cfg_hold", cap, cfg);
      if (code == MODE_CLOCK) begin
        chk("oe_clk", 8'h00, tp_oe_n);
        chk("tp_low", 8'h00, o_tp & 8'hC8);
        chk("tp_60m", 8'(o_tp[0]), 8'(o_tp[5]));
        for (int b = 0; b < 8; b++) r[b] += int'(o_tp[b] & ~prev[b]);
      end else begin
        chk("oe_quiet", 8'hFF, tp_oe_n);
        chk("tp_quiet", 8'h00, o_tp);
      end
      prev = o_tp;
    end
    if (code == MODE_CLOCK) begin
      chk("ref_seen", 8'h01, 8'(r[0] > 20));
      chk("div_30m", 8'h01, near(2 * r[1], r[0], 4));
      chk("div_15m", 8'h01, near(4 * r[4], r[0], 8));
      chk("div_7m5", 8'h01, near(8 * r[2], r[0], 16));
    end
  endtask : watch

  initial begin
    void'($urandom(32'h37ED));
    boot(MODE_QUIET, 8'($urandom));
    watch(MODE_QUIET);
    // every code, back to back, ending away from the default
    for (int i = 0; i < 8; i++) begin
      sw_write(3'(7 - i));
      watch(3'(7 - i));
    end
    boot(MODE_CLOCK, 8'hFF);
    watch(MODE_CLOCK);
    c = 3'($urandom);
    boot(c, 8'($urandom));
    watch(c);
    conclude();
  end
endmodule : reset_strap_debug_port_test
